/* include/psm_defs.svh */
// power-saving mode control: register address, field positions, reset value, timing
// assumes an 8-bit special-function register space and a core clock equal to the oscillator
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

`define PSM_POWER_CONTROL_ADDR 8'h87
`define PSM_POWER_CONTROL_RST  8'h00

`define PSM_BIT_BAUD_DOUBLE    7
`define PSM_BIT_PD_START       6
`define PSM_BIT_IDLE_START     5
`define PSM_BIT_RESERVED       4
`define PSM_BIT_USER_FLAG_1    3
`define PSM_BIT_USER_FLAG_0    2
`define PSM_BIT_PD_ENABLE      1
`define PSM_BIT_IDLE_ENABLE    0

// one machine cycle is this many oscillator periods, two per state
`define PSM_OSC_PER_MCYCLE     4'd12
`define PSM_MCYCLE_LAST        4'd11
`define PSM_CLK_PERIOD_NS      40

`endif

/* include/psm_pkg.sv */
// types shared by the power-saving mode control block
// assumes nothing beyond a SystemVerilog compiler
package psm_pkg;

  typedef enum logic [1:0] {
    psm_mode_run,
    psm_mode_idle,
    psm_mode_pdown
  } psm_mode_e;

  typedef logic [2:0] psm_state_t;

endpackage

/* design/psm_mcycle_gen.sv */
// machine-cycle generator: divides the oscillator clock by twelve
// assumes i_core_clk is the oscillator itself; the count runs in every mode that keeps the clock
`timescale 1ns/10ps
`include "psm_defs.svh"

module psm_mcycle_gen (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  output logic                    o_mcycle_en,
  output psm_pkg::psm_state_t     o_state_idx
);

  logic [3:0] osc_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // twelve oscillator periods per machine cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_cnt_reg <= 4'h0;
    end else if (osc_cnt_reg == `PSM_MCYCLE_LAST) begin
      osc_cnt_reg <= 4'h0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mcycle_en <= 1'b0;
    end else begin
      o_mcycle_en <= (osc_cnt_reg == (`PSM_MCYCLE_LAST - 4'h1));
    end
  end

  // state index 0..5, two oscillator periods each
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state_idx <= 3'h0;
    end else begin
      o_state_idx <= osc_cnt_reg[3:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  AST_MCYCLE_PERIOD: assert property (o_mcycle_en |-> ##12 o_mcycle_en)
    else $error("machine cycle pulse not twelve clocks apart");
  AST_MCYCLE_GAP: assert property (o_mcycle_en |=> !o_mcycle_en [*8])
    else $error("machine cycle pulse repeated too early");

endmodule

/* design/psm_ctrl.sv */
// power-saving mode control: power control register, idle and power-down sequencing
// assumes a core on the same clock issuing special-function register reads and writes,
// an interrupt controller on the same clock, and the permit pin arriving asynchronously
`timescale 1ns/10ps
`include "psm_defs.svh"

module psm_ctrl #(
  parameter bit HAS_POWER_SAVE = 1'b1
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic [7:0]         i_sfr_addr,
  input  wire logic               i_sfr_wr,
  input  wire logic               i_sfr_rd,
  input  wire logic [7:0]         i_sfr_wdata,
  output logic [7:0]              o_sfr_rdata,
  output logic                    o_sfr_hit,
  input  wire logic               i_power_save_permit_n,
  input  wire logic               i_irq_req,
  output logic                    o_baud_double,
  output logic                    o_cpu_clk_en,
  output logic                    o_periph_clk_en,
  output logic                    o_osc_en,
  output logic                    o_ram_retain,
  output logic                    o_idle_wake,
  output logic                    o_mcycle_en,
  output psm_pkg::psm_state_t     o_state_idx
);

  function automatic logic sfr_match(input logic [7:0] addr);
    sfr_match = (addr == `PSM_POWER_CONTROL_ADDR);
  endfunction

  // register reset image, sized so single fields can be picked from it
  localparam logic [7:0] RST_VIEW = `PSM_POWER_CONTROL_RST;

  psm_pkg::psm_mode_e mode_reg;
  logic               permit_meta_reg;
  logic               permit_sync_reg;
  logic               baud_double_reg;
  logic               powerdown_start_reg;
  logic               idle_start_reg;
  logic               user_flag_1_reg;
  logic               user_flag_0_reg;
  logic               powerdown_enable_reg;
  logic               idle_enable_reg;
  logic               pend_pd_reg;
  logic               pend_idle_reg;
  logic               permit_ok;
  logic               wr_hit;
  logic               pd_go;
  logic               idle_go;
  logic               wake;
  logic [7:0]         reg_view;

  ////////////////////////////////////////////////////////////////////////////
  psm_mcycle_gen u_mcycle (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .o_mcycle_en (o_mcycle_en),
    .o_state_idx (o_state_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // permit pin is asynchronous; only the second stage is read
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      permit_meta_reg <= 1'b1;
      permit_sync_reg <= 1'b1;
    end else begin
      permit_meta_reg <= i_power_save_permit_n;
      permit_sync_reg <= permit_meta_reg;
    end
  end

  assign permit_ok = HAS_POWER_SAVE && !permit_sync_reg;
  assign wr_hit    = i_sfr_wr && sfr_match(i_sfr_addr) && (mode_reg == psm_pkg::psm_mode_run);

  // enable must already be stored from an earlier write: a single stray write cannot start a mode
  assign pd_go   = wr_hit && i_sfr_wdata[`PSM_BIT_PD_START] && powerdown_enable_reg && permit_ok;
  assign idle_go = wr_hit && i_sfr_wdata[`PSM_BIT_IDLE_START] && idle_enable_reg && permit_ok
                   && !pd_go;
  assign wake    = (mode_reg == psm_pkg::psm_mode_idle) && i_irq_req;

  ////////////////////////////////////////////////////////////////////////////
  // register fields
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      baud_double_reg <= RST_VIEW[`PSM_BIT_BAUD_DOUBLE];
    end else if (wr_hit) begin
      baud_double_reg <= i_sfr_wdata[`PSM_BIT_BAUD_DOUBLE];
    end
  end

  // flags are never touched by mode entry or wake-up
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      user_flag_1_reg <= 1'b0;
      user_flag_0_reg <= 1'b0;
    end else if (wr_hit && HAS_POWER_SAVE) begin
      user_flag_1_reg <= i_sfr_wdata[`PSM_BIT_USER_FLAG_1];
      user_flag_0_reg <= i_sfr_wdata[`PSM_BIT_USER_FLAG_0];
    end
  end

  // enables are consumed by a successful start so each entry needs a fresh arm
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      powerdown_enable_reg <= 1'b0;
      idle_enable_reg      <= 1'b0;
    end else if (pd_go || idle_go) begin
      powerdown_enable_reg <= 1'b0;
      idle_enable_reg      <= 1'b0;
    end else if (wr_hit && HAS_POWER_SAVE) begin
      powerdown_enable_reg <= i_sfr_wdata[`PSM_BIT_PD_ENABLE];
      idle_enable_reg      <= i_sfr_wdata[`PSM_BIT_IDLE_ENABLE];
    end
  end

  // start bits stay set while the mode lasts; only an accepted start sets them
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      powerdown_start_reg <= 1'b0;
      idle_start_reg      <= 1'b0;
    end else begin
      if (pd_go) begin
        powerdown_start_reg <= 1'b1;
      end else if (pend_pd_reg && !permit_ok) begin
        powerdown_start_reg <= 1'b0;
      end
      if (idle_go) begin
        idle_start_reg <= 1'b1;
      end else if (wake || (pend_idle_reg && !permit_ok)) begin
        idle_start_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry waits for the end of the current machine cycle so the setting instruction completes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_pd_reg   <= 1'b0;
      pend_idle_reg <= 1'b0;
    end else begin
      if (pd_go) begin
        pend_pd_reg <= 1'b1;
      end else if (o_mcycle_en || !permit_ok) begin
        pend_pd_reg <= 1'b0;
      end
      if (idle_go) begin
        pend_idle_reg <= 1'b1;
      end else if (o_mcycle_en || !permit_ok) begin
        pend_idle_reg <= 1'b0;
      end
    end
  end

  // power-down has no exit but reset: the oscillator is gone
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= psm_pkg::psm_mode_run;
    end else begin
      case (mode_reg)
        psm_pkg::psm_mode_run: begin
          if (o_mcycle_en && pend_pd_reg && permit_ok) begin
            mode_reg <= psm_pkg::psm_mode_pdown;
          end else if (o_mcycle_en && pend_idle_reg && permit_ok) begin
            mode_reg <= psm_pkg::psm_mode_idle;
          end
        end
        psm_pkg::psm_mode_idle: begin
          if (wake) begin
            mode_reg <= psm_pkg::psm_mode_run;
          end
        end
        default: begin
          mode_reg <= psm_pkg::psm_mode_pdown;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_idle_wake <= 1'b0;
    end else begin
      o_idle_wake <= wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side; reduced variant shows only the baud doubling bit
  always_comb begin
    reg_view = 8'h00;
    reg_view[`PSM_BIT_BAUD_DOUBLE] = baud_double_reg;
    if (HAS_POWER_SAVE) begin
      reg_view[`PSM_BIT_PD_START]    = powerdown_start_reg;
      reg_view[`PSM_BIT_IDLE_START]  = idle_start_reg;
      reg_view[`PSM_BIT_USER_FLAG_1] = user_flag_1_reg;
      reg_view[`PSM_BIT_USER_FLAG_0] = user_flag_0_reg;
      reg_view[`PSM_BIT_PD_ENABLE]   = powerdown_enable_reg;
      reg_view[`PSM_BIT_IDLE_ENABLE] = idle_enable_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd && sfr_match(i_sfr_addr)) begin
      o_sfr_rdata <= reg_view;
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  assign o_sfr_hit       = sfr_match(i_sfr_addr) && (i_sfr_rd || i_sfr_wr);
  assign o_baud_double   = baud_double_reg;
  assign o_cpu_clk_en    = (mode_reg == psm_pkg::psm_mode_run);
  assign o_periph_clk_en = (mode_reg != psm_pkg::psm_mode_pdown);
  assign o_osc_en        = (mode_reg != psm_pkg::psm_mode_pdown);
  assign o_ram_retain    = (mode_reg == psm_pkg::psm_mode_pdown);

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  AST_VARIANT_BITS: assert property (!HAS_POWER_SAVE |-> o_sfr_rdata[6:0] == 7'h00)
    else $error("reduced variant shows bits other than baud doubling");
  AST_BAUD_WRITE: assert property (wr_hit |=> o_baud_double == $past(i_sfr_wdata[7]))
    else $error("baud doubling output does not follow write");
  AST_PD_ENTRY: assert property (pd_go |-> ##[1:13] (o_ram_retain || !permit_ok))
    else $error("power-down not entered within one machine cycle");
  AST_IDLE_ENTRY: assert property (idle_go ##1 permit_ok [*8] |-> ##[0:5]
                                   (mode_reg == psm_pkg::psm_mode_idle || !permit_ok))
    else $error("idle not entered within one machine cycle");
  AST_PD_NEEDS_ENABLE: assert property ($rose(o_ram_retain) |-> $past(pend_pd_reg))
    else $error("power-down entered without armed enable");
  AST_IDLE_NEEDS_ENABLE: assert property (idle_go |-> idle_enable_reg)
    else $error("idle start accepted without enable");
  AST_FLAGS_HOLD: assert property ((mode_reg == psm_pkg::psm_mode_idle)
                                   |=> $stable({user_flag_1_reg, user_flag_0_reg}))
    else $error("general flags changed during idle");
  AST_PERMIT_BLOCKS: assert property (!permit_ok |-> !pd_go && !idle_go)
    else $error("mode start accepted while not permitted");
  AST_WAKE: assert property (wake |=> o_cpu_clk_en && o_idle_wake)
    else $error("interrupt did not end idle");
  AST_PD_CLOCKS: assert property (o_ram_retain |-> !o_osc_en && !o_periph_clk_en && !o_cpu_clk_en)
    else $error("clocks running in power-down");
  AST_RESERVED_ZERO: assert property (o_sfr_rdata[4] == 1'b0)
    else $error("reserved bit reads one");

  COV_IDLE_WAKE: cover property ((mode_reg == psm_pkg::psm_mode_idle) ##[1:50] o_idle_wake);
  COV_PDOWN: cover property ($rose(o_ram_retain));
  COV_BLOCKED: cover property (wr_hit && i_sfr_wdata[6] && powerdown_enable_reg && !permit_ok);

endmodule

/* tb/tb.sv */
// self-checking bench for the power-saving mode control block, full and reduced register variants
// assumes psm_defs.svh on the include path; the bench drives every port of both instances itself
`timescale 1ns/10ps
`include "psm_defs.svh"

`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin err_count++; $display("ERROR %0t %s", $time, msg); end end

module tb;
  localparam logic [7:0] ADDR = `PSM_POWER_CONTROL_ADDR;
  logic                i_core_clk;
  logic                i_rst_n;
  logic [7:0]          sfr_addr;
  logic                sfr_wr;
  logic                sfr_rd;
  logic [7:0]          sfr_wdata;
  logic                permit_n;
  logic                irq_req;
  logic [7:0]          rdata;
  logic                hit;
  logic                baud;
  logic                cpu_en;
  logic                per_en;
  logic                osc_en;
  logic                retain;
  logic                wake;
  logic                mc_en;
  psm_pkg::psm_state_t state_idx;
  logic [7:0]          lite_rdata;
  logic                lite_baud;
  int                  err_count;
  int                  n_tests;
  logic [7:0]          d;
  logic [7:0]          dl;
  logic                h;

  psm_ctrl #(.HAS_POWER_SAVE(1'b1)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .i_power_save_permit_n(permit_n), .i_irq_req(irq_req), .o_baud_double(baud), .o_cpu_clk_en(cpu_en),
    .o_periph_clk_en(per_en), .o_osc_en(osc_en), .o_ram_retain(retain), .o_idle_wake(wake),
    .o_mcycle_en(mc_en), .o_state_idx(state_idx));

  // reduced variant shares the bus; only its register view and baud doubling output are judged
  psm_ctrl #(.HAS_POWER_SAVE(1'b0)) dut_lite (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(lite_rdata), .o_sfr_hit(),
    .i_power_save_permit_n(permit_n), .i_irq_req(irq_req), .o_baud_double(lite_baud), .o_cpu_clk_en(),
    .o_periph_clk_en(), .o_osc_en(), .o_ram_retain(), .o_idle_wake(), .o_mcycle_en(), .o_state_idx());

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #(`PSM_CLK_PERIOD_NS / 2) i_core_clk = ~i_core_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge i_core_clk);
    sfr_wr    <= 1'b0;
  endtask

  // hit is combinational, so it is looked at while the strobe is up
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    #1 h = hit;
    @(posedge i_core_clk);
    sfr_rd   <= 1'b0;
    #1 d = rdata;
    dl = lite_rdata;
  endtask

  // entry waits for the next machine-cycle boundary, at most twelve clocks
  task automatic wait_clear(input bit pd);
    int i;
    for (i = 0; i < 14 && (pd ? osc_en : cpu_en) !== 1'b0; i++) begin
      @(posedge i_core_clk);
      #1;
    end
  endtask

  task automatic irq_pulse();
    @(posedge i_core_clk);
    irq_req <= 1'b1;
    @(posedge i_core_clk);
    irq_req <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_reg(ADDR);
    `CHK(d, 8'h00, "reset value")
    `CHK(cpu_en & per_en & osc_en & ~retain, 1'b1, "run mode after reset")
    wr_reg(ADDR, 8'h9c);
    rd_reg(ADDR);
    `CHK(d, 8'h8c, "flags and baud bit kept, reserved bit zero")
    `CHK(h, 1'b1, "hit on own address")
    `CHK(baud, 1'b1, "baud doubling output")
    `CHK(dl, 8'h80, "reduced variant keeps only bit 7")
    `CHK(lite_baud, 1'b1, "reduced variant baud output")
    wr_reg(8'h86, 8'h00);
    rd_reg(8'h88);
    `CHK(d, 8'h00, "unmapped read data")
    `CHK(h, 1'b0, "unmapped hit")
    rd_reg(ADDR);
    `CHK(d, 8'h8c, "unmapped write ignored")
    wr_reg(ADDR, 8'h00);
    #1 `CHK(baud, 1'b0, "baud doubling cleared")
    $display("test regs done");
  endtask

  task automatic t_refused();
    wr_reg(ADDR, 8'h01);
    wr_reg(ADDR, 8'h21);
    repeat (14) @(posedge i_core_clk);
    #1 `CHK(cpu_en, 1'b1, "idle entered while permit pin forbids")
    permit_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    wr_reg(ADDR, 8'h00);
    wr_reg(ADDR, 8'h21);
    repeat (14) @(posedge i_core_clk);
    #1 `CHK(cpu_en, 1'b1, "start in the same write as enable")
    wr_reg(ADDR, 8'h00);
    wr_reg(ADDR, 8'h20);
    repeat (14) @(posedge i_core_clk);
    #1 `CHK(cpu_en, 1'b1, "idle start without enable")
    wr_reg(ADDR, 8'h00);
    wr_reg(ADDR, 8'h40);
    repeat (14) @(posedge i_core_clk);
    #1 `CHK(osc_en, 1'b1, "power-down start without enable")
    wr_reg(ADDR, 8'h00);
    $display("test refused done");
  endtask

  task automatic t_idle();
    wr_reg(ADDR, 8'h0d);
    wr_reg(ADDR, 8'h2c);
    wait_clear(1'b0);
    `CHK(cpu_en, 1'b0, "idle entry")
    `CHK({per_en, osc_en, retain}, 3'b110, "peripherals run in idle")
    repeat (5) @(posedge i_core_clk);
    irq_pulse();
    `CHK({cpu_en, wake}, 2'b11, "interrupt ends idle")
    @(posedge i_core_clk);
    #1 `CHK(wake, 1'b0, "wake pulse one cycle")
    rd_reg(ADDR);
    `CHK(d, 8'h0c, "flags kept, start and enables cleared")
    $display("test idle done");
  endtask

  task automatic t_mcycle();
    int n;
    n = 0;
    while (mc_en !== 1'b1 && n < 14) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (mc_en !== 1'b1 && n < 20);
    `CHK(n, 12, "machine cycle length")
    `CHK(state_idx, 3'h5, "last state at machine-cycle pulse")
    repeat (2) @(posedge i_core_clk);
    #1 `CHK(state_idx, 3'h0, "first state after boundary")
    $display("test mcycle done");
  endtask

  task automatic t_pdown();
    // both modes armed and started together: power-down must win
    wr_reg(ADDR, 8'h03);
    wr_reg(ADDR, 8'h60);
    wait_clear(1'b1);
    `CHK({osc_en, per_en, cpu_en}, 3'b000, "power-down stops all clocks")
    `CHK(retain, 1'b1, "data memory retained")
    rd_reg(ADDR);
    `CHK(d, 8'h40, "power-down wins over idle, enables consumed")
    irq_pulse();
    repeat (3) @(posedge i_core_clk);
    #1 `CHK(osc_en, 1'b0, "interrupt must not leave power-down")
    // power-down is left by reset only, this is also the mid-run reset
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    #1 `CHK({osc_en, retain}, 2'b10, "reset leaves power-down")
    rd_reg(ADDR);
    `CHK(d, 8'h00, "register after reset")
    $display("test pdown done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    n_tests   = 0;
    i_rst_n   = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
    permit_n  = 1'b1;
    irq_req   = 1'b0;
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    t_regs();
    t_refused();
    t_idle();
    t_mcycle();
    t_pdown();
    end_of_test();
  end

  // the tests need well under a thousand clocks
  initial begin
    #(5000 * `PSM_CLK_PERIOD_NS);
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
